// File: hw/adc_consts.vh
// Constants shared by the converter control block and its two helpers.
`ifndef ADC_CONSTS_VH
`define ADC_CONSTS_VH

// Register byte offsets on the APB bus.
`define OFF_CONTROL 12'h000
`define OFF_CONFIG 12'h004
`define OFF_TRIGGER 12'h008
`define OFF_RES_HIGH 12'h00C
`define OFF_RES_LOW 12'h010

// Control register fields.
`define CTL_ON_BIT 0
`define CTL_GO_BIT 1
`define CTL_CHAN_HI 7
`define CTL_CHAN_LO 2

// Conversion configuration fields.
`define CFG_JUST_BIT 7
`define CFG_CLK_HI 6
`define CFG_CLK_LO 4
`define CFG_REF_HI 1
`define CFG_REF_LO 0

// Trigger register field.
`define TRG_SRC_HI 4
`define TRG_SRC_LO 0
`define TRG_NONE 5'h00

// Reset values.
`define RST_BYTE 8'h00
`define RST_CHAN 6'h00
`define RST_CLK 3'h0
`define RST_REF 2'h0
`define RST_TRG 5'h00

// Conversion clock select codes.
`define CLK_DIV2 3'h0
`define CLK_DIV8 3'h1
`define CLK_DIV32 3'h2
`define CLK_RC_A 3'h3
`define CLK_DIV4 3'h4
`define CLK_DIV16 3'h5
`define CLK_DIV64 3'h6
`define CLK_RC_B 3'h7

// Divider terminal counts, one less than the division ratio.
`define TERM_DIV2 6'h01
`define TERM_DIV4 6'h03
`define TERM_DIV8 6'h07
`define TERM_DIV16 6'h0F
`define TERM_DIV32 6'h1F
`define TERM_DIV64 6'h3F
`define CNT_ZERO 6'h00
`define CNT_ONE 6'h01

// Positive reference codes and one-hot routes.
`define REF_SUPPLY 2'h0
`define REF_RESERVED 2'h1
`define REF_PIN 2'h2
`define REF_FIXED 2'h3
`define ROUTE_SUPPLY 3'h1
`define ROUTE_PIN 3'h2
`define ROUTE_FIXED 3'h4
`define ROUTE_NONE 3'h0

// Successive approximation constants.
`define SAR_MSB 4'h9
`define SAR_LSB 4'h0
`define SAR_STEP 4'h1
`define SAR_FIRST 10'h200
`define SAR_CLEAR 10'h000

// Result packing pads.
`define PAD6 6'h00

// APB answer constants.
`define RDATA_ZERO 32'h00000000
`define RDATA_PAD 24'h000000

`endif

// File: hw/conv_clock_divider.v
// Conversion clock tick generator: divides the system clock or passes RC ticks.
`timescale 1ns/1ns
`default_nettype none
`include "adc_consts.vh"

module conv_clock_divider (
	// Clock and reset.
	input wire pclk,
	input wire presetn,
	// Control.
	input wire enable,
	input wire [2:0] clock_select,
	input wire rc_tick,
	// Tick out.
	output reg tick_r
);

	reg [5:0] cnt_r;
	reg [5:0] term;
	wire use_rc;

	// Terminal count per system clock ratio.
	always @* begin
		case (clock_select)
			`CLK_DIV2: term = `TERM_DIV2;
			`CLK_DIV4: term = `TERM_DIV4;
			`CLK_DIV8: term = `TERM_DIV8;
			`CLK_DIV16: term = `TERM_DIV16;
			`CLK_DIV32: term = `TERM_DIV32;
			`CLK_DIV64: term = `TERM_DIV64;
			default: term = `TERM_DIV2;
		endcase
	end

	// Both unused codes pick the dedicated RC clock.
	assign use_rc = (clock_select == `CLK_RC_A) ||
		(clock_select == `CLK_RC_B);

	// The >= compare recovers cleanly if the ratio shrinks mid-count.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= `CNT_ZERO;
			tick_r <= 1'b0;
		end else if (!enable) begin
			cnt_r <= `CNT_ZERO;
			tick_r <= 1'b0;
		end else if (use_rc) begin
			cnt_r <= `CNT_ZERO;
			tick_r <= rc_tick;
		end else if (cnt_r >= term) begin
			cnt_r <= `CNT_ZERO;
			tick_r <= 1'b1;
		end else begin
			cnt_r <= cnt_r + `CNT_ONE;
			tick_r <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// File: hw/trigger_edge.v
// Auto-conversion trigger selection with rising edge detection.
`timescale 1ns/1ns
`default_nettype none
`include "adc_consts.vh"

module trigger_edge (
	// Clock and reset.
	input wire pclk,
	input wire presetn,
	// Sources and selection.
	input wire [31:0] sources,
	input wire [4:0] source_select,
	// Edge pulse out.
	output reg edge_r
);

	reg [31:0] prev_r;
	wire rise;

	// Every source is tracked, so a change of selection does not fake an edge.
	assign rise = sources[source_select] & ~prev_r[source_select];

	// Code zero selects no trigger at all.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= `RDATA_ZERO;
			edge_r <= 1'b0;
		end else begin
			prev_r <= sources;
			edge_r <= rise && (source_select != `TRG_NONE);
		end
	end

endmodule
`default_nettype wire

// File: hw/adc_control.v
// Converter control block: APB registers, clocking, triggers, SAR, result.
//
// Overview of operation
// - Right justify zeros high byte upper six bits
// - Left justify zeros low byte lower six bits
// - Clock field picks divider ratio or RC
// - Reference field routes supply, pin or fixed
// - Five-bit trigger field, upper bits read zero
// - Triggers react only to rising edges
// - Left: result 9..2 into high byte
// - Left: result 1..0 into low 7..6
// - Right: result 9..8 into high 1..0
// - Right: result 7..0 into low byte
// - Control clears on reset; results keep contents
// - Go bit starts, stays set, self-clears
// - Converter off means disabled, no current
// - Channel field in control bits 7..2
//
// Register map, one byte per word in the low lane:
//   control at 0x000: channel in 7..2, go in 1, enable in 0.
//   conversion_config at 0x004: justify 7, clock 6..4, reference 1..0.
//   auto_trigger_select at 0x008: source code in 4..0.
//   result_high_byte at 0x00C and result_low_byte at 0x010.
// Every access takes one wait state; unmapped words answer with an error.
// A conversion is one hold tick plus ten bit ticks of the chosen clock.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "adc_consts.vh"

module adc_control (
	// Clock and reset.
	input wire pclk,
	input wire presetn,
	// APB slave.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_r,
	output reg pready_r,
	output reg pslverr_r,
	// Analog front end.
	input wire comparator_above,
	input wire rc_clock_tick,
	input wire [31:0] trigger_sources,
	output reg converter_on_r,
	output reg [5:0] input_channel_select_r,
	output reg [2:0] reference_route_r,
	output reg sample_hold_r,
	output reg [9:0] sar_trial_r
);

	// Sequencer states: idle, sample hold, and bit-by-bit conversion.
	localparam ST_IDLE = 2'h0;
	localparam ST_HOLD = 2'h1;
	localparam ST_CONV = 2'h2;

	// Sequencer, configuration and result state.
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [3:0] bit_r;
	reg [3:0] bit_nxt;
	reg [9:0] trial_nxt;
	reg go_r;
	reg result_justify_select_r;
	reg [2:0] conversion_clock_select_r;
	reg [1:0] positive_reference_select_r;
	reg [4:0] auto_trigger_source_r;
	reg [7:0] result_high_byte_r;
	reg [7:0] result_low_byte_r;
	reg [7:0] read_byte;
	reg hit;
	reg [7:0] pack_high;
	reg [7:0] pack_low;
	reg done;

	// Bus strobes and internal events.
	wire access;
	wire apb_done;
	wire wr;
	wire [7:0] wbyte;
	wire conv_tick;
	wire trig_edge;
	wire sw_go;
	wire sw_stop;
	wire start;
	wire abort;

	// Clock ticks for the SAR steps.
	// The divider idles while the converter is off, which saves toggling.
	conv_clock_divider u_div (
		.pclk(pclk),
		.presetn(presetn),
		.enable(converter_on_r),
		.clock_select(conversion_clock_select_r),
		.rc_tick(rc_clock_tick),
		.tick_r(conv_tick)
	);

	// Selected trigger source, edge detected.
	// Edges are tracked even while busy; they are simply not used then.
	trigger_edge u_trig (
		.pclk(pclk),
		.presetn(presetn),
		.sources(trigger_sources),
		.source_select(auto_trigger_source_r),
		.edge_r(trig_edge)
	);

	// The slave inserts one wait state so read data comes from a flop.
	assign access = psel && penable;
	assign apb_done = access && pready_r;
	assign wr = apb_done && pwrite && !pslverr_r;
	assign wbyte = pwdata[7:0];

	// Go written as one with the enable also one in the same word.
	assign sw_go = wr && (paddr == `OFF_CONTROL) &&
		wbyte[`CTL_GO_BIT] && wbyte[`CTL_ON_BIT];
	// Writing go as zero, or the enable as zero, stops a conversion.
	assign sw_stop = wr && (paddr == `OFF_CONTROL) &&
		(!wbyte[`CTL_GO_BIT] || !wbyte[`CTL_ON_BIT]);
	// Software needs the enable in the same word as go, so one write can
	// power up and start; a trigger only counts while already powered.
	// A stop written in the same cycle as a trigger edge wins, so a
	// conversion never begins with the converter switched off.
	assign start = (state_r == ST_IDLE) && !sw_stop &&
		(sw_go || (converter_on_r && trig_edge));
	assign abort = (state_r != ST_IDLE) && sw_stop;

	// Address decode and read mux for the low byte lane.
	always @* begin
		hit = 1'b1;
		read_byte = `RST_BYTE;
		case (paddr)
			`OFF_CONTROL: read_byte = {input_channel_select_r, go_r,
				converter_on_r};
			`OFF_CONFIG: read_byte = {result_justify_select_r,
				conversion_clock_select_r, 2'b00,
				positive_reference_select_r};
			// Bits 7 to 5 of the trigger register read as zero.
			`OFF_TRIGGER: read_byte = {3'b000, auto_trigger_source_r};
			`OFF_RES_HIGH: read_byte = result_high_byte_r;
			`OFF_RES_LOW: read_byte = result_low_byte_r;
			default: hit = 1'b0;
		endcase
	end

	// APB answer: ready one cycle into access, error on unmapped address.
	// Read data loads on every transfer, writes included, and holds between transfers; only the strobe counts.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= `RDATA_ZERO;
		end else begin
			pready_r <= access && !pready_r;
			if (access && !pready_r) begin
				pslverr_r <= !hit;
				prdata_r <= {`RDATA_PAD, read_byte};
			end else begin
				pslverr_r <= 1'b0;
			end
		end
	end

	// Configuration registers clear on every reset.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			converter_on_r <= 1'b0;
			input_channel_select_r <= `RST_CHAN;
			result_justify_select_r <= 1'b0;
			conversion_clock_select_r <= `RST_CLK;
			positive_reference_select_r <= `RST_REF;
			auto_trigger_source_r <= `RST_TRG;
		end else if (wr) begin
			if (paddr == `OFF_CONTROL) begin
				converter_on_r <= wbyte[`CTL_ON_BIT];
				input_channel_select_r <=
					wbyte[`CTL_CHAN_HI:`CTL_CHAN_LO];
			end
			if (paddr == `OFF_CONFIG) begin
				result_justify_select_r <= wbyte[`CFG_JUST_BIT];
				conversion_clock_select_r <=
					wbyte[`CFG_CLK_HI:`CFG_CLK_LO];
				positive_reference_select_r <=
					wbyte[`CFG_REF_HI:`CFG_REF_LO];
			end
			if (paddr == `OFF_TRIGGER) begin
				auto_trigger_source_r <=
					wbyte[`TRG_SRC_HI:`TRG_SRC_LO];
			end
		end
	end

	// Reference routing; the reserved code connects nothing.
	// The route is registered so the analog switches see a clean level
	// one cycle after a configuration write.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reference_route_r <= `ROUTE_SUPPLY;
		end else begin
			case (positive_reference_select_r)
				`REF_SUPPLY: reference_route_r <= `ROUTE_SUPPLY;
				`REF_PIN: reference_route_r <= `ROUTE_PIN;
				`REF_FIXED: reference_route_r <= `ROUTE_FIXED;
				default: reference_route_r <= `ROUTE_NONE;
			endcase
		end
	end

	// SAR sequencer: one tick to hold the sample, then one tick per bit.
	// The trial word doubles as the DAC drive, so the result is simply the
	// trial word left behind after the last bit decision.
	always @* begin
		state_nxt = state_r;
		bit_nxt = bit_r;
		trial_nxt = sar_trial_r;
		done = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (start) begin
					state_nxt = ST_HOLD;
					bit_nxt = `SAR_MSB;
					trial_nxt = `SAR_FIRST;
				end
			end
			ST_HOLD: begin
				if (conv_tick) begin
					state_nxt = ST_CONV;
				end
			end
			ST_CONV: begin
				if (conv_tick) begin
					if (!comparator_above) begin
						trial_nxt[bit_r] = 1'b0;
					end
					if (bit_r == `SAR_LSB) begin
						state_nxt = ST_IDLE;
						done = 1'b1;
					end else begin
						bit_nxt = bit_r - `SAR_STEP;
						trial_nxt[bit_nxt] = 1'b1;
					end
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		// A stop cancels the conversion; if the last bit lands in the
		// same cycle, the finished word still loads, since completion
		// wins over the clear of the busy flag.
		if (abort) begin
			state_nxt = ST_IDLE;
		end
	end

	// Sequencer state; the go flag mirrors the conversion in progress.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			bit_r <= `SAR_MSB;
			sar_trial_r <= `SAR_CLEAR;
			go_r <= 1'b0;
			sample_hold_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			bit_r <= bit_nxt;
			sar_trial_r <= trial_nxt;
			go_r <= (state_nxt != ST_IDLE);
			sample_hold_r <= (state_nxt != ST_IDLE);
		end
	end

	// Pack the finished word in the format chosen at completion.
	// Packing reads the next trial word, so the load edge stores the final
	// decision of bit zero rather than the stale trial.
	always @* begin
		if (result_justify_select_r) begin
			pack_high = {`PAD6, trial_nxt[9:8]};
			pack_low = trial_nxt[7:0];
		end else begin
			pack_high = trial_nxt[9:2];
			pack_low = {trial_nxt[1:0], `PAD6};
		end
	end

	// Results have no reset, so they survive a warm reset.
	// Hardware loading wins over a software write in the same cycle.
	// Software may overwrite either byte, which only matters until the
	// next completion.
	always @(posedge pclk) begin
		if (done) begin
			result_high_byte_r <= pack_high;
			result_low_byte_r <= pack_low;
		end else if (wr && (paddr == `OFF_RES_HIGH)) begin
			result_high_byte_r <= wbyte;
		end else if (wr && (paddr == `OFF_RES_LOW)) begin
			result_low_byte_r <= wbyte;
		end
	end

endmodule
`default_nettype wire

// File: test/adc_control_asserts.sv
// Port-level checker for the converter control block.
`timescale 1ns/1ns
`default_nettype none
`include "adc_consts.vh"
module adc_control_asserts (
	// Clock and reset.
	input wire pclk,
	input wire presetn,
	// APB.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata_r,
	input wire pready_r,
	input wire pslverr_r,
	// Analog side.
	input wire converter_on_r,
	input wire [5:0] input_channel_select_r,
	input wire [2:0] reference_route_r,
	input wire sample_hold_r,
	input wire [9:0] sar_trial_r
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Completed reads, and completed writes to the control register.
	wire rd = pready_r && !pwrite;
	wire wr_ctl = pready_r && pwrite && paddr == `OFF_CONTROL;
	// One wait state, then a single-cycle answer.
	pready_wait_a: assert property (psel && penable && !pready_r |=> pready_r)
		else $error("pready late");
	pready_pulse_a: assert property (pready_r |=> !pready_r)
		else $error("pready too long");
	err_zero_a: assert property (rd && pslverr_r |-> prdata_r == 0)
		else $error("error read not zero");
	trig_pad_a: assert property (
		rd && paddr == `OFF_TRIGGER |-> prdata_r[7:5] == 0)
		else $error("trigger pad bits set");
	// A conversion opens with the MSB trial and only while powered.
	start_trial_a: assert property (
		$rose(sample_hold_r) |-> sar_trial_r == 10'h200 && converter_on_r)
		else $error("bad conversion start");
	trial_busy_a: assert property (
		$changed(sar_trial_r) |-> sample_hold_r || $past(sample_hold_r))
		else $error("trial moved while idle");
	route_hot_a: assert property ($onehot0(reference_route_r))
		else $error("two references routed");
	// Channel and power follow only software writes to control.
	chan_write_a: assert property (
		$changed(input_channel_select_r) |-> $past(wr_ctl))
		else $error("channel changed unasked");
	on_write_a: assert property (
		$changed(converter_on_r) |-> $past(wr_ctl))
		else $error("power changed unasked");
	cover property ($rose(sample_hold_r));
	cover property ($fell(sample_hold_r));
	cover property (pready_r && pslverr_r);
endmodule
bind adc_control adc_control_asserts u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
	.converter_on_r(converter_on_r), .sample_hold_r(sample_hold_r),
	.input_channel_select_r(input_channel_select_r),
	.reference_route_r(reference_route_r), .sar_trial_r(sar_trial_r));
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ns
`default_nettype none
`include "adc_consts.vh"
module tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata_r, q, trigger_sources = 0;
	logic pready_r, pslverr_r, err, comparator_above = 0, rc_clock_tick = 0;
	logic converter_on_r, sample_hold_r;
	logic [5:0] input_channel_select_r;
	logic [2:0] reference_route_r;
	logic [9:0] sar_trial_r, tgt = 0;
	int miscompares = 0, n_checks = 0, hl = 0, rcn = 0;
	int ratio [8] = '{2, 8, 32, 3, 4, 16, 64, 3};
	logic [2:0] route [4] = '{3'h1, 3'h0, 3'h2, 3'h4};
	adc_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
		.comparator_above(comparator_above), .rc_clock_tick(rc_clock_tick),
		.trigger_sources(trigger_sources), .converter_on_r(converter_on_r),
		.input_channel_select_r(input_channel_select_r),
		.reference_route_r(reference_route_r), .sample_hold_r(sample_hold_r),
		.sar_trial_r(sar_trial_r));
	always #2 pclk = ~pclk;
	// The input sits at tgt; a comparator one cycle late still beats the
	// next tick. RC ticks come every third cycle; hl counts busy cycles.
	always @(posedge pclk) begin
		comparator_above <= tgt >= sar_trial_r;
		rcn <= (rcn == 2) ? 0 : rcn + 1;
		rc_clock_tick <= rcn == 2;
		hl <= sample_hold_r ? hl + 1 : hl;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One APB transfer; an idle cycle follows so strobes never glitch.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready_r !== 1'b1 && n < 20);
		q = prdata_r;
		err = pslverr_r;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready_r !== 1'b1) begin
			chk(0, 1);
			summarize();
		end
		@(posedge pclk);
	endtask
	// Waits for a conversion to start and then to finish.
	task automatic conv_wait;
		int n;
		n = 0;
		while (sample_hold_r !== 1'b1 && n < 10) begin
			@(posedge pclk);
			n++;
		end
		chk(sample_hold_r, 1);
		while (sample_hold_r === 1'b1 && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		chk(sample_hold_r, 0);
		if (n >= 2000) summarize();
	endtask
	task automatic res(input logic j, input logic [9:0] t);
		apb(0, `OFF_RES_HIGH, 8'h00);
		chk(q, {24'h0, j ? {6'h00, t[9:8]} : t[9:2]});
		apb(0, `OFF_RES_LOW, 8'h00);
		chk(q, {24'h0, j ? t[7:0] : {t[1:0], 6'h00}});
	endtask
	initial begin
		int h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(reference_route_r, 3'h1);
		apb(1, `OFF_CONFIG, 8'hFF);
		apb(0, `OFF_CONFIG, 8'h00);
		chk(q, 32'h000000F3);
		apb(1, `OFF_TRIGGER, 8'hE3);
		apb(0, `OFF_TRIGGER, 8'h00);
		chk(q, 32'h00000003);
		apb(0, 12'h014, 8'h00);
		chk({q[30:0], err}, 32'h00000001);
		for (int i = 0; i < 4; i++) begin
			apb(1, `OFF_CONFIG, i[7:0]);
			@(posedge pclk);
			chk(reference_route_r, route[i]);
		end
		$display("test registers done");
		// Every clock code, alternating format; busy time shows the ratio.
		for (int i = 0; i < 8; i++) begin
			tgt <= {i[2:0], 4'h9, ~i[2:0]};
			apb(1, `OFF_CONFIG, {i[0], i[2:0], 4'h0});
			apb(1, `OFF_CONTROL, 8'h17);
			h0 = hl;
			conv_wait();
			h0 = hl - h0;
			chk(h0 >= 10 * ratio[i] && h0 <= 11 * ratio[i] + 3, 1);
			res(i[0], tgt);
		end
		chk({converter_on_r, input_channel_select_r}, 7'h45);
		apb(0, `OFF_CONTROL, 8'h00);
		chk(q, 32'h00000015);
		$display("test conversions done");
		// Source 3 rises once, stays high, then falls: one start only.
		apb(1, `OFF_CONTROL, 8'h01);
		tgt <= 10'h2A5;
		trigger_sources <= 32'h00000008;
		conv_wait();
		res(1, 10'h2A5);
		h0 = hl;
		repeat (20) @(posedge pclk);
		trigger_sources <= 32'h00000000;
		repeat (20) @(posedge pclk);
		chk(hl - h0, 0);
		// Abort mid-conversion leaves the old result in place.
		apb(1, `OFF_CONFIG, 8'h60);
		apb(1, `OFF_CONTROL, 8'h03);
		repeat (100) @(posedge pclk);
		apb(1, `OFF_CONTROL, 8'h01);
		@(posedge pclk);
		chk(sample_hold_r, 0);
		res(1, 10'h2A5);
		$display("test trigger and abort done");
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 3; i++) begin
			apb(0, 12'(4 * i), 8'h00);
			chk(q, 0);
		end
		res(1, 10'h2A5);
		$display("test reset done");
		summarize();
	end
endmodule
`default_nettype wire
